// *** rtl/tcio_pkg.sv ***
// Shared constants for the timecode input and output register block.
package tcio_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam logic [15:0] OFF_IN_ENABLE = 16'h6000;
  localparam logic [15:0] OFF_IN_ERROR = 16'h600C;
  localparam logic [15:0] OFF_IN_SECONDS = 16'h6020;
  localparam logic [15:0] OFF_IN_MINUTES = 16'h6024;
  localparam logic [15:0] OFF_IN_DAYS = 16'h602C;
  localparam logic [15:0] OFF_IN_YEARS = 16'h6030;
  localparam logic [15:0] OFF_IN_CTRL_BITS = 16'h6034;
  localparam logic [15:0] OFF_IN_SBS = 16'h6038;
  localparam logic [15:0] OFF_OUT_ENABLE = 16'h6060;
  localparam logic [15:0] OFF_OUT_CONTROL = 16'h6064;
  localparam logic [15:0] OFF_OUT_ADJUST = 16'h6068;
  localparam logic [15:0] OFF_OUT_LEAP_TIME = 16'h606C;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned POS_PPS_OK = 24;
  localparam int unsigned POS_AM_FRAME = 16;
  localparam int unsigned POS_DCLS_FRAME = 8;
  localparam int unsigned POS_SYNC = 0;
  localparam int unsigned SEC_W = 7;
  localparam int unsigned MIN_W = 7;
  localparam int unsigned DAY_W = 10;
  localparam int unsigned YEAR_W = 8;
  localparam int unsigned CTRL_BITS_W = 18;
  localparam int unsigned SBS_W = 17;
  localparam int unsigned ADJ_W = 12;
  localparam int unsigned POS_LEAP_YEAR = 24;
  localparam int unsigned POS_INSERT_LEAP = 16;
  localparam int unsigned POS_LEAP_YEAR_FLD = 24;
  localparam int unsigned POS_LEAP_DAY_FLD = 8;
  localparam int unsigned POS_LEAP_SEC_FLD = 0;
  localparam int unsigned LEAP_DAY_W = 9;
  localparam int unsigned LEAP_SEC_W = 6;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FRAME_PERIOD_NS = 1000000000;
  localparam int unsigned FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// *** rtl/tcio_sat_cnt.sv ***
// Saturating event counter with synchronous clear.
`timescale 1ns/1ns
module tcio_sat_cnt #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic inc_i,
  output logic [WIDTH-1:0] count_o
);
  localparam logic [WIDTH-1:0] MAX_VAL = '1;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_o <= '0;
    end
    else if (ce_i)
    begin
      if (clr_i)
      begin
        count_o <= '0;
      end
      else if (inc_i && count_o != MAX_VAL)
      begin
        count_o <= count_o + 1'b1;
      end
    end
  end

  property p_sat_hold;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !clr_i && count_o == MAX_VAL) |=> count_o == MAX_VAL;
  endproperty
  a_sat_hold: assert property (p_sat_hold) else $error("Counter left saturation.");
endmodule

// *** rtl/tcio_top.sv ***
// Timecode input decode registers and output control registers.
`timescale 1ns/1ns
module tcio_top #(
  parameter int unsigned FRAME_CYCLES = tcio_pkg::FRAME_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  input wire logic pps_ok_i,
  input wire logic am_frame_err_i,
  input wire logic dcls_frame_err_i,
  input wire logic sync_err_i,
  input wire logic frame_valid_i,
  input wire logic [6:0] frame_seconds_i,
  input wire logic [6:0] frame_minutes_i,
  input wire logic [9:0] frame_days_i,
  input wire logic [7:0] frame_years_i,
  input wire logic [17:0] frame_ctrl_bits_i,
  input wire logic [16:0] frame_sbs_i,
  input wire logic [5:0] out_seconds_i,
  input wire logic [8:0] out_days_i,
  input wire logic [7:0] out_years_i,
  output logic in_enable_o,
  output logic in_reset_o,
  output logic out_enable_o,
  output logic out_reset_o,
  output logic leap_insert_o,
  output logic tx_start_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic wr_in_en;
  logic wr_out_en;
  logic in_toggle;
  logic in_rise;
  logic out_toggle;
  logic [31:0] err_word;
  logic [3:0] err_events;
  logic [6:0] sec_reg;
  logic [6:0] min_reg;
  logic [9:0] day_reg;
  logic [7:0] year_reg;
  logic [17:0] cbits_reg;
  logic [16:0] sbs_reg;
  logic insert_reg;
  logic leap_year_reg;
  logic [11:0] adjust_reg;
  logic [31:0] leap_time_reg;
  logic [31:0] phase_reg;
  logic leap_match;
  logic [31:0] tx_point;

  // Leap year test on a two-digit BCD year.
  function automatic logic bcd_leap(input logic [7:0] yr);
    logic [3:0] units;
    units = yr[3:0];
    if (yr[4])
    begin
      bcd_leap = (units == 4'h2) || (units == 4'h6);
    end
    else
    begin
      bcd_leap = (units == 4'h0) || (units == 4'h4) || (units == 4'h8);
    end
  endfunction

  assign wr_in_en = reg_wr_i && reg_addr_i == tcio_pkg::OFF_IN_ENABLE;
  assign wr_out_en = reg_wr_i && reg_addr_i == tcio_pkg::OFF_OUT_ENABLE;
  assign in_toggle = ce_i && wr_in_en && reg_wdata_i[0] != in_enable_o;
  assign in_rise = in_toggle && reg_wdata_i[0];
  assign out_toggle = ce_i && wr_out_en && reg_wdata_i[0] != out_enable_o;

  ////////////////////////////////////////////////////////////////////////////
  // Input enable and reset.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      in_enable_o <= 1'b0;
      in_reset_o <= 1'b0;
    end
    else if (ce_i)
    begin
      in_reset_o <= in_toggle;
      if (wr_in_en)
      begin
        in_enable_o <= reg_wdata_i[0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_enable_o <= 1'b0;
      out_reset_o <= 1'b0;
    end
    else if (ce_i)
    begin
      out_reset_o <= out_toggle;
      if (wr_out_en)
      begin
        out_enable_o <= reg_wdata_i[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign err_events[3] = in_enable_o && pps_ok_i;
  assign err_events[2] = in_enable_o && am_frame_err_i;
  assign err_events[1] = in_enable_o && dcls_frame_err_i;
  assign err_events[0] = in_enable_o && sync_err_i;

  for (genvar g = 0; g < 4; g++)
  begin : g_err
    tcio_sat_cnt #(
      .WIDTH(tcio_pkg::CNT_W)
    ) u_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .clr_i(in_toggle),
      .inc_i(err_events[g]),
      .count_o(err_word[g*8 +: 8])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture a whole frame at once.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sec_reg <= '0;
      min_reg <= '0;
      day_reg <= '0;
      year_reg <= '0;
      cbits_reg <= '0;
      sbs_reg <= '0;
    end
    else if (ce_i)
    begin
      if (in_toggle)
      begin
        sec_reg <= '0;
        min_reg <= '0;
        day_reg <= '0;
        year_reg <= '0;
        cbits_reg <= '0;
        sbs_reg <= '0;
      end
      else if (in_enable_o && frame_valid_i)
      begin
        sec_reg <= frame_seconds_i;
        min_reg <= frame_minutes_i;
        day_reg <= frame_days_i;
        year_reg <= frame_years_i;
        cbits_reg <= frame_ctrl_bits_i;
        sbs_reg <= frame_sbs_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign leap_match = out_seconds_i ==
    leap_time_reg[tcio_pkg::POS_LEAP_SEC_FLD +: tcio_pkg::LEAP_SEC_W]
    && out_days_i == leap_time_reg[tcio_pkg::POS_LEAP_DAY_FLD +: tcio_pkg::LEAP_DAY_W]
    && out_years_i == leap_time_reg[tcio_pkg::POS_LEAP_YEAR_FLD +: tcio_pkg::YEAR_W];

  // Output settings: adjust, leap time and leap request.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      adjust_reg <= '0;
      leap_time_reg <= tcio_pkg::RESET_WORD;
      insert_reg <= 1'b0;
      leap_insert_o <= 1'b0;
    end
    else if (ce_i)
    begin
      leap_insert_o <= 1'b0;
      if (out_toggle)
      begin
        adjust_reg <= '0;
        leap_time_reg <= tcio_pkg::RESET_WORD;
        insert_reg <= 1'b0;
      end
      else
      begin
        if (reg_wr_i && reg_addr_i == tcio_pkg::OFF_OUT_ADJUST)
        begin
          adjust_reg <= reg_wdata_i[tcio_pkg::ADJ_W-1:0];
        end
        if (reg_wr_i && reg_addr_i == tcio_pkg::OFF_OUT_LEAP_TIME)
        begin
          leap_time_reg <= reg_wdata_i;
        end
        if (insert_reg && out_enable_o && leap_match)
        begin
          insert_reg <= 1'b0;
          leap_insert_o <= 1'b1;
        end
        else if (reg_wr_i && reg_addr_i == tcio_pkg::OFF_OUT_CONTROL)
        begin
          insert_reg <= reg_wdata_i[tcio_pkg::POS_INSERT_LEAP];
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      leap_year_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      leap_year_reg <= bcd_leap(out_years_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Launch point moves earlier by adjust.
  assign tx_point = FRAME_CYCLES - 32'd1 - {20'h00000, adjust_reg};

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase_reg <= '0;
      tx_start_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (out_toggle || !out_enable_o)
      begin
        phase_reg <= '0;
        tx_start_o <= 1'b0;
      end
      else
      begin
        tx_start_o <= phase_reg == tx_point;
        if (phase_reg == FRAME_CYCLES - 32'd1)
        begin
          phase_reg <= '0;
        end
        else
        begin
          phase_reg <= phase_reg + 32'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= tcio_pkg::RESET_WORD;
      reg_ack_o <= 1'b0;
    end
    else if (ce_i)
    begin
      reg_ack_o <= reg_rd_i || reg_wr_i;
      reg_rdata_o <= tcio_pkg::RESET_WORD;
      if (reg_rd_i)
      begin
        if (reg_addr_i == tcio_pkg::OFF_IN_ENABLE)
        begin
          reg_rdata_o <= {31'h00000000, in_enable_o};
        end
        else if (reg_addr_i == tcio_pkg::OFF_IN_ERROR)
        begin
          reg_rdata_o <= err_word;
        end
        else if (reg_addr_i == tcio_pkg::OFF_IN_SECONDS)
        begin
          reg_rdata_o <= {25'h0000000, sec_reg};
        end
        else if (reg_addr_i == tcio_pkg::OFF_IN_MINUTES)
        begin
          reg_rdata_o <= {25'h0000000, min_reg};
        end
        else if (reg_addr_i == tcio_pkg::OFF_IN_DAYS)
        begin
          reg_rdata_o <= {22'h000000, day_reg};
        end
        else if (reg_addr_i == tcio_pkg::OFF_IN_YEARS)
        begin
          reg_rdata_o <= {24'h000000, year_reg};
        end
        else if (reg_addr_i == tcio_pkg::OFF_IN_CTRL_BITS)
        begin
          reg_rdata_o <= {14'h0000, cbits_reg};
        end
        else if (reg_addr_i == tcio_pkg::OFF_IN_SBS)
        begin
          reg_rdata_o <= {15'h0000, sbs_reg};
        end
        else if (reg_addr_i == tcio_pkg::OFF_OUT_ENABLE)
        begin
          reg_rdata_o <= {31'h00000000, out_enable_o};
        end
        else if (reg_addr_i == tcio_pkg::OFF_OUT_CONTROL)
        begin
          reg_rdata_o[tcio_pkg::POS_LEAP_YEAR] <= leap_year_reg;
          reg_rdata_o[tcio_pkg::POS_INSERT_LEAP] <= insert_reg;
        end
        else if (reg_addr_i == tcio_pkg::OFF_OUT_ADJUST)
        begin
          reg_rdata_o <= {20'h00000, adjust_reg};
        end
        else if (reg_addr_i == tcio_pkg::OFF_OUT_LEAP_TIME)
        begin
          reg_rdata_o <= leap_time_reg;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_pps_count;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !in_toggle && in_enable_o && pps_ok_i && err_word[31:24] != 8'hFF)
    |=> err_word[31:24] == $past(err_word[31:24]) + 8'h01;
  endproperty
  a_pps_count: assert property (p_pps_count) else $error("PPS count missed.");

  property p_am_count;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !in_toggle && in_enable_o && am_frame_err_i && err_word[23:16] != 8'hFF)
    |=> err_word[23:16] != $past(err_word[23:16]);
  endproperty
  a_am_count: assert property (p_am_count) else $error("AM count missed.");

  property p_clear_on_enable;
    @(posedge clk_i) disable iff (rst_i)
    in_rise |=> err_word == 32'h00000000 && in_enable_o;
  endproperty
  a_clear_on_enable: assert property (p_clear_on_enable) else $error("Counts not cleared.");

  property p_in_reset;
    @(posedge clk_i) disable iff (rst_i)
    in_toggle |=> in_reset_o && sec_reg == 7'h00 && sbs_reg == 17'h00000;
  endproperty
  a_in_reset: assert property (p_in_reset) else $error("Input side not reset.");

  property p_frame_capture;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && in_enable_o && !in_toggle && frame_valid_i)
    |=> sec_reg == $past(frame_seconds_i) && year_reg == $past(frame_years_i);
  endproperty
  a_frame_capture: assert property (p_frame_capture) else $error("Frame not captured.");

  property p_out_reset;
    @(posedge clk_i) disable iff (rst_i)
    out_toggle |=> out_reset_o && adjust_reg == 12'h000 && !insert_reg;
  endproperty
  a_out_reset: assert property (p_out_reset) else $error("Output side not reset.");

  property p_leap_insert;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !out_toggle && insert_reg && out_enable_o && leap_match)
    |=> leap_insert_o && !insert_reg ##1 (!leap_insert_o || !$past(ce_i));
  endproperty
  a_leap_insert: assert property (p_leap_insert) else $error("Leap second not inserted.");

  property p_tx_early;
    @(posedge clk_i) disable iff (rst_i)
    (tx_start_o && $past(ce_i)) |-> $past(phase_reg) == $past(tx_point);
  endproperty
  a_tx_early: assert property (p_tx_early) else $error("Launch not advanced by adjust.");

  property p_adjust_write;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !out_toggle && reg_wr_i && reg_addr_i == tcio_pkg::OFF_OUT_ADJUST)
    |=> adjust_reg == $past(reg_wdata_i[11:0]);
  endproperty
  a_adjust_write: assert property (p_adjust_write) else $error("Adjust not stored.");
endmodule

// *** dv/tcio_src_model.sv ***
// Timecode source model driving decoder event pulses and decoded frame fields.
`timescale 1ns/1ns
module tcio_src_model (
  input wire logic clk_i,
  output logic pps_ok_o,
  output logic am_err_o,
  output logic dcls_err_o,
  output logic sync_err_o,
  output logic frame_valid_o,
  output logic [66:0] fields_o
);
  initial
  begin
    {pps_ok_o, am_err_o, dcls_err_o, sync_err_o, frame_valid_o} = 5'h00;
    fields_o = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Fires one cycle of decoder events, one bit per event kind.
  task automatic events(input logic [3:0] mask);
    @(posedge clk_i);
    {pps_ok_o, am_err_o, dcls_err_o, sync_err_o} <= mask;
    @(posedge clk_i);
    {pps_ok_o, am_err_o, dcls_err_o, sync_err_o} <= 4'h0;
  endtask
  // Presents a frame for one cycle, then scrambles the fields so stale data is never valid.
  task automatic frame(input logic [66:0] f);
    @(posedge clk_i);
    fields_o <= f;
    frame_valid_o <= 1'b1;
    @(posedge clk_i);
    fields_o <= ~f;
    frame_valid_o <= 1'b0;
  endtask
endmodule

// *** dv/tcio_top_bench.sv ***
// Self-checking bench for the timecode register block.
`timescale 1ns/1ns
module tcio_top_bench;
  localparam int FC = 64;
  localparam int LIMIT = 20000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [15:0] reg_addr_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_wdata_i = 32'h00000000;
  logic [31:0] reg_rdata_o;
  logic reg_ack_o, pps, am, dcls, sync, fv, in_en, in_rst, out_en, out_rst, leap, tx;
  logic [66:0] fld;
  logic [5:0] osec = 6'h00;
  logic [8:0] oday = 9'h000;
  logic [7:0] oyear = 8'h00;
  logic [66:0] frm_m = '0;
  logic [15:0] offs[14] = '{16'h6000, 16'h6004, 16'h600C, 16'h6020, 16'h6024, 16'h602C,
    16'h6030, 16'h6034, 16'h6038, 16'h6060, 16'h6064, 16'h6068, 16'h606C, 16'h6070};
  logic [7:0] years[7] = '{8'h00, 8'h02, 8'h04, 8'h12, 8'h30, 8'h96, 8'h99};
  int num_errors = 0, checks_done = 0, cyc = 0, seed = 98;
  int cnt[4] = '{0, 0, 0, 0};
  int in_en_m = 0, out_en_m = 0, adj_m = 0, lt_m = 0, ins_m = 0;
  int n_in_rst = 0, n_out_rst = 0, n_leap = 0, a, t;
  int tx_q[$];
  always #5 clk_i = ~clk_i;
  tcio_src_model i_src (.clk_i(clk_i), .pps_ok_o(pps), .am_err_o(am), .dcls_err_o(dcls),
    .sync_err_o(sync), .frame_valid_o(fv), .fields_o(fld));
  tcio_top #(.FRAME_CYCLES(FC)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
    .pps_ok_i(pps), .am_frame_err_i(am), .dcls_frame_err_i(dcls), .sync_err_i(sync),
    .frame_valid_i(fv), .frame_seconds_i(fld[66:60]), .frame_minutes_i(fld[59:53]),
    .frame_days_i(fld[52:43]), .frame_years_i(fld[42:35]), .frame_ctrl_bits_i(fld[34:17]),
    .frame_sbs_i(fld[16:0]), .out_seconds_i(osec), .out_days_i(oday), .out_years_i(oyear),
    .in_enable_o(in_en), .in_reset_o(in_rst), .out_enable_o(out_en), .out_reset_o(out_rst),
    .leap_insert_o(leap), .tx_start_o(tx));
  ////////////////////////////////////////////////////////////////////////////////
  // Counts cycles, output pulses and transmit launch times; cuts a hang short.
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (tx === 1'b1) tx_q.push_back(cyc);
    if (in_rst === 1'b1) n_in_rst <= n_in_rst + 1;
    if (out_rst === 1'b1) n_out_rst <= n_out_rst + 1;
    if (leap === 1'b1) n_leap <= n_leap + 1;
    if (cyc == LIMIT)
    begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic leap_yr(input logic [7:0] y);
    return ((y[7:4] * 10 + y[3:0]) % 4) == 0;
  endfunction
  // Expected read value of every register from the model state.
  function automatic logic [31:0] exp_rd(input logic [15:0] ad);
    logic [31:0] d;
    d = 32'h00000000;
    case (ad)
      16'h6000: d[0] = in_en_m[0];
      16'h600C: d = {cnt[3][7:0], cnt[2][7:0], cnt[1][7:0], cnt[0][7:0]};
      16'h6020: d[6:0] = frm_m[66:60];
      16'h6024: d[6:0] = frm_m[59:53];
      16'h602C: d[9:0] = frm_m[52:43];
      16'h6030: d[7:0] = frm_m[42:35];
      16'h6034: d[17:0] = frm_m[34:17];
      16'h6038: d[16:0] = frm_m[16:0];
      16'h6060: d[0] = out_en_m[0];
      16'h6064: d = {7'h00, leap_yr(oyear), 7'h00, ins_m[0], 16'h0000};
      16'h6068: d = adj_m;
      16'h606C: d = lt_m;
      default: d = 32'h00000000;
    endcase
    return d;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] ad, input logic [31:0] w);
    @(posedge clk_i);
    reg_addr_i <= ad;
    reg_wdata_i <= w;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1 chk("write ack", {31'h0, reg_ack_o}, 32'h1); // Bus handshake.
    if (ad == 16'h6000 && w[0] != in_en_m[0])
    begin
      in_en_m = w[0];
      cnt = '{0, 0, 0, 0};
      frm_m = '0;
    end
    if (ad == 16'h6060 && w[0] != out_en_m[0])
    begin
      out_en_m = w[0];
      adj_m = 0;
      lt_m = 0;
      ins_m = 0;
    end
    if (ad == 16'h6064) ins_m = w[16];
    if (ad == 16'h6068) adj_m = w & 32'h00000FFF;
    if (ad == 16'h606C) lt_m = w & 32'hFF01FF3F;
  endtask
  task automatic rd(input logic [15:0] ad, input string what);
    logic [31:0] d;
    @(posedge clk_i);
    reg_addr_i <= ad;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
    chk("read ack", {31'h0, reg_ack_o}, 32'h1); // Bus handshake.
    chk(what, d, exp_rd(ad)); // Register model.
  endtask
  task automatic ev(input logic [3:0] m);
    i_src.events(m);
    for (int i = 0; i < 4; i++)
      if (in_en_m != 0 && m[i] && cnt[i] < 255) cnt[i]++;
  endtask
  task automatic wait_tx(input int k);
    int n0;
    n0 = tx_q.size();
    while (tx_q.size() < n0 + k) @(posedge clk_i);
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (offs[i]) rd(offs[i], "reset value"); // Reset map.
    wr(16'h6020, 32'hFFFFFFFF);
    rd(16'h6020, "read-only seconds"); // Read-only field.
    ev(4'hF);
    rd(16'h600C, "counts while disabled"); // Gated counts.
    wr(16'h6000, 32'h00000001);
    wr(16'h6000, 32'h00000001);
    repeat (2) @(posedge clk_i);
    chk("input reset pulses", n_in_rst, 32'h1); // One pulse per toggle.
    chk("input enable pin", in_en, 32'h1); // Input enabled.
    for (int i = 0; i < 300; i++) ev($random(seed) | 1);
    rd(16'h600C, "error counts"); // Saturating counts.
    for (int i = 0; i < 3; i++)
    begin
      frm_m = 67'({$random(seed), $random(seed), $random(seed)});
      i_src.frame(frm_m);
      rd(16'h6020, "seconds"); // Seconds field.
      rd(16'h6024, "minutes"); // Minutes field.
      rd(16'h602C, "days"); // Days field.
      rd(16'h6030, "years"); // Years field.
      rd(16'h6034, "control bits"); // Control field.
      rd(16'h6038, "binary seconds"); // Binary seconds.
    end
    wr(16'h6000, 32'h00000000);
    rd(16'h6020, "seconds after toggle"); // Input side reset.
    ev(4'hF);
    wr(16'h6000, 32'h00000001);
    rd(16'h600C, "counts after enable"); // Cleared counts.
    ev(4'h9);
    rd(16'h600C, "counts restart"); // Counting again.
    wr(16'h6060, 32'h00000001);
    foreach (years[i])
    begin
      @(posedge clk_i);
      oyear <= years[i];
      rd(16'h6064, "leap year flag"); // Leap year flag.
    end
    wait_tx(2);
    chk("plain frame period", tx_q[$] - tx_q[$-1], FC); // Unshifted period.
    a = 1 + $unsigned($random(seed)) % 40;
    wr(16'h6068, a);
    rd(16'h6068, "output adjust"); // Adjust held.
    wait_tx(2);
    chk("shifted interval", tx_q[$-1] - tx_q[$-2], FC - a); // Earlier launch.
    chk("period after shift", tx_q[$] - tx_q[$-1], FC); // Period kept.
    t = $unsigned($random(seed)) % 59;
    @(posedge clk_i);
    oday <= 9'($random(seed));
    osec <= 6'(t + 1);
    @(posedge clk_i);
    wr(16'h606C, {oyear, 7'h00, oday, 2'h0, 6'(t)});
    rd(16'h606C, "leap time"); // Leap time held.
    wr(16'h6064, 32'h00010000);
    repeat (5) @(posedge clk_i);
    chk("no early insert", n_leap, 32'h0); // No insert before time.
    rd(16'h6064, "insert armed"); // Insert bit set.
    @(posedge clk_i);
    osec <= 6'(t);
    repeat (4) @(posedge clk_i);
    chk("leap insert pulses", n_leap, 32'h1); // Insert at time.
    ins_m = 0;
    rd(16'h6064, "insert done"); // Insert bit cleared.
    @(posedge clk_i);
    osec <= 6'(t + 1);
    wr(16'h6064, 32'h00010000);
    wr(16'h6060, 32'h00000000);
    repeat (2) @(posedge clk_i);
    chk("output reset pulses", n_out_rst, 32'h2); // One pulse per toggle.
    chk("output enable pin", out_en, 32'h0); // Output disabled.
    chk("no insert after rearm", n_leap, 32'h1); // Armed but not due.
    rd(16'h6068, "adjust after toggle"); // Output side reset.
    rd(16'h606C, "leap time after toggle"); // Output side reset.
    rd(16'h6064, "control after toggle"); // Output side reset.
    @(posedge clk_i);
    ce_i <= 1'b0;
    reg_addr_i <= 16'h6068;
    reg_wdata_i <= 32'h00000ABC;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    ce_i <= 1'b1;
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
    chk("ack while frozen", {31'h0, reg_ack_o}, 32'h0); // Frozen bus.
    rd(16'h6068, "adjust while frozen"); // Frozen write ignored.
    report_and_stop();
  end
endmodule
